// file: rtl/iscs_defs.svh
// Behaviour
// - Analog input maps linearly: lowest raw gives scale low, highest gives scale high.
// - Temperature input ignores and hides scale high, scale low and decimal settings.
// - Scaled value carries decimal digits from decimal setting; limits share that resolution.
// - Split heat/cool control only in heat/cool mode, else single-output control.
// - Defaults: out1 heating, out2 unassigned, aux1..3 carry alarms 1..3.
// - Mode change reinitialises assignments; cooling to out2 if fitted, else aux2.
// - With program pattern on, aux1 output shows program end.
// - Direct action swaps heating and cooling roles of assigned outputs.
// - Event input with inversion function inverts configured action while it is on.
// - Dead band centred on set point; negative width gives overlap band.
// - Dead band resets to zero.
// - Heating uses base band; cooling uses base band times cooling coefficient.
// - One cooling coefficient per PID set; edits hit the set in use.
// - Optional auto-tune coefficient capture in heat/cool mode, disabled by default.
// - Dead band and cooling coefficient usable only in heat/cool mode.
`ifndef ISCS_DEFS_SVH
`define ISCS_DEFS_SVH
`define ISCS_A_CTRL    8'h00
`define ISCS_A_SCL_HI  8'h04
`define ISCS_A_SCL_LO  8'h08
`define ISCS_A_DEC     8'h0C
`define ISCS_A_DBAND   8'h10
`define ISCS_A_COEF    8'h14
`define ISCS_A_PBAND   8'h18
`define ISCS_A_SP      8'h1C
`define ISCS_A_ASSIGN  8'h20
`define ISCS_A_PV      8'h24
`define ISCS_A_MV      8'h28
`define ISCS_A_STAT    8'h2C
`define ISCS_B_ANALOG  0
`define ISCS_B_HC      1
`define ISCS_B_DIRECT  2
`define ISCS_B_HAS_O2  3
`define ISCS_B_PROG    4
`define ISCS_B_EVINV   5
`define ISCS_B_ATCOEF  6
`define ISCS_CTRL_RST  32'h0000_0008
`define ISCS_HI_RST    16'h03E8
`define ISCS_LO_RST    16'h0000
`define ISCS_DEC_RST   2'h1
`define ISCS_DB_RST    16'h0000
`define ISCS_COEF_RST  16'h0064
`define ISCS_PB_RST    16'h0050
`define ISCS_SP_RST    16'h0000
`define ISCS_ASG_RST   32'h0005_4301
`define ISCS_MV_FULL   8'h64
`endif

// file: rtl/iscs_pkg.sv
// Types shared by the scaling and heat/cool split block
package iscs_pkg;
  typedef enum logic [2:0] {
    ISCS_SRC_NONE = 3'b000,
    ISCS_SRC_HEAT = 3'b001,
    ISCS_SRC_COOL = 3'b010,
    ISCS_SRC_ALM1 = 3'b011,
    ISCS_SRC_ALM2 = 3'b100,
    ISCS_SRC_ALM3 = 3'b101
  } iscs_src_t;
  typedef enum logic [1:0] {
    ISCS_WR_IDLE = 2'b00,
    ISCS_WR_RESP = 2'b01
  } iscs_wst_t;
endpackage : iscs_pkg

// file: rtl/iscs_top.sv
// Input scaling and heating/cooling output split with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "iscs_defs.svh"
module iscs_top #(
  parameter logic [15:0] ADC_FULL = 16'hFFFF
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Sensor and event pins
  input  wire logic [15:0] adc_raw_i,
  input  wire logic [15:0] temp_pv_i,
  input  wire logic        event_in_i,
  input  wire logic [2:0]  alarm_i,
  input  wire logic        prog_end_i,
  // Auto-tuning result, same clock
  input  wire logic        auto_tuning_done_i,
  input  wire logic [15:0] auto_tuning_coef_i,
  // Outputs
  output logic             ctrl_out1_o,
  output logic             ctrl_out2_o,
  output logic [2:0]       aux_out_o,
  output logic [7:0]       mv_heat_o,
  output logic [7:0]       mv_cool_o,
  output logic [15:0]      pv_o,
  output logic [1:0]       pv_decimals_o
);
  import iscs_pkg::*;

  // Percent output from excess over a band edge
  // Floors the percentage; zero band means full output
  function automatic logic [7:0] prop_mv(input logic signed [17:0] x,
                                         input logic [31:0] band);
    logic signed [40:0] p;
    p = 41'(x) * 41'sd100;
    if (x <= 18'sd0)
      prop_mv = 8'h00;
    else if (band == 32'd0 || p >= $signed({9'd0, band}) * 41'sd100 / 41'sd100 * 41'sd1
             && p / $signed({9'd0, band}) >= 41'sd100)
      prop_mv = `ISCS_MV_FULL;
    else
      prop_mv = 8'(p / $signed({9'd0, band}));
  endfunction : prop_mv

  logic [31:0]        ctrl_r;
  logic signed [15:0] scl_hi_r, scl_lo_r, dband_r, sp_r;
  logic [1:0]         dec_r;
  logic [15:0]        pband_r;
  logic [15:0]        coef_r [4];
  logic [31:0]        asg_r;
  logic               hc_q_r;
  logic [15:0]        adc_s1_r, adc_s2_r, tpv_s1_r, tpv_s2_r;
  logic               ev_s1_r, ev_s2_r, pe_s1_r, pe_s2_r;
  logic [2:0]         alm_s1_r, alm_s2_r;
  logic signed [15:0] pv_r;
  logic [7:0]         mvh_r, mvc_r;
  logic               aw_got_r, w_got_r;
  logic [7:0]         aw_addr_r;
  logic [31:0]        w_data_r;
  logic [3:0]         w_strb_r;
  iscs_wst_t          wst_r;
  logic               rvalid_r;
  logic [31:0]        rdata_r;
  logic [1:0]         rresp_r, bresp_r;

  logic analog, hc, direct_eff;
  logic [1:0] pid_sel;
  assign analog  = ctrl_r[`ISCS_B_ANALOG];
  assign hc      = ctrl_r[`ISCS_B_HC];
  assign pid_sel = ctrl_r[9:8];
  // Event inversion flips the configured action while on
  assign direct_eff = ctrl_r[`ISCS_B_DIRECT] ^ (ctrl_r[`ISCS_B_EVINV] & ev_s2_r);

  // Wide samples may tear for one cycle; the sensor moves slowly
  // Pin synchronisers
  always_ff @(posedge clk_i) begin
    adc_s1_r <= adc_raw_i;
    adc_s2_r <= adc_s1_r;
    tpv_s1_r <= temp_pv_i;
    tpv_s2_r <= tpv_s1_r;
    ev_s1_r  <= event_in_i;
    ev_s2_r  <= ev_s1_r;
    pe_s1_r  <= prog_end_i;
    pe_s2_r  <= pe_s1_r;
    alm_s1_r <= alarm_i;
    alm_s2_r <= alm_s1_r;
  end

  // Write channel: address and data taken in either order
  // Response must drain before either half is taken again
  logic wr_fire;
  logic [7:0]  wa;
  logic [31:0] wd;
  assign s_axi_awready_o = !aw_got_r && wst_r == ISCS_WR_IDLE;
  assign s_axi_wready_o  = !w_got_r && wst_r == ISCS_WR_IDLE;
  assign wr_fire = wst_r == ISCS_WR_IDLE
                   && (aw_got_r || s_axi_awvalid_i) && (w_got_r || s_axi_wvalid_i);
  assign wa = aw_got_r ? aw_addr_r : s_axi_awaddr_i;
  always_comb begin
    logic [31:0] d;
    logic [3:0]  s;
    d = w_got_r ? w_data_r : s_axi_wdata_i;
    s = w_got_r ? w_strb_r : s_axi_wstrb_i;
    wd = 32'h0000_0000;
    for (int i = 0; i < 4; i++)
      wd[i*8 +: 8] = s[i] ? d[i*8 +: 8] : 8'h00;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      wst_r     <= ISCS_WR_IDLE;
      bresp_r   <= 2'b00;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        wst_r    <= ISCS_WR_RESP;
        bresp_r  <= (wa[1:0] == 2'b00 && wa <= `ISCS_A_STAT) ? 2'b00 : 2'b10;
      end else if (wst_r == ISCS_WR_RESP && s_axi_bready_i) begin
        wst_r <= ISCS_WR_IDLE;
      end
    end
  end
  assign s_axi_bvalid_o = wst_r == ISCS_WR_RESP;
  assign s_axi_bresp_o  = bresp_r;

  // Configuration registers; partial strobes leave unstrobed lanes at zero
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl_r   <= `ISCS_CTRL_RST;
      scl_hi_r <= `ISCS_HI_RST;
      scl_lo_r <= `ISCS_LO_RST;
      dec_r    <= `ISCS_DEC_RST;
      dband_r  <= `ISCS_DB_RST;
      pband_r  <= `ISCS_PB_RST;
      sp_r     <= `ISCS_SP_RST;
    end else if (wr_fire) begin
      case (wa)
        `ISCS_A_CTRL:   ctrl_r <= {22'd0, wd[9:8], 1'b0, wd[6:0]};
        // Scaling settings locked out for temperature input
        `ISCS_A_SCL_HI: if (analog) scl_hi_r <= wd[15:0];
        `ISCS_A_SCL_LO: if (analog) scl_lo_r <= wd[15:0];
        `ISCS_A_DEC:    if (analog) dec_r <= wd[1:0];
        `ISCS_A_DBAND:  if (hc) dband_r <= wd[15:0];
        `ISCS_A_PBAND:  pband_r <= wd[15:0];
        `ISCS_A_SP:     sp_r <= wd[15:0];
        default: ;
      endcase
    end
  end

  // Cooling coefficient per PID set; auto-tune capture wins over a write
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 4; i++)
        coef_r[i] <= `ISCS_COEF_RST;
    end else if (auto_tuning_done_i && hc && ctrl_r[`ISCS_B_ATCOEF]) begin
      coef_r[pid_sel] <= auto_tuning_coef_i;
    end else if (wr_fire && wa == `ISCS_A_COEF && hc) begin
      coef_r[pid_sel] <= wd[15:0];
    end
  end

  // Output assignment; a mode change rewrites it over any same-cycle write
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      hc_q_r <= 1'b0;
      asg_r  <= `ISCS_ASG_RST;
    end else begin
      hc_q_r <= hc;
      if (hc != hc_q_r) begin
        asg_r[2:0]   <= ISCS_SRC_HEAT;
        asg_r[6:4]   <= (hc && ctrl_r[`ISCS_B_HAS_O2]) ? ISCS_SRC_COOL : ISCS_SRC_NONE;
        asg_r[10:8]  <= ISCS_SRC_ALM1;
        asg_r[14:12] <= (hc && !ctrl_r[`ISCS_B_HAS_O2]) ? ISCS_SRC_COOL : ISCS_SRC_ALM2;
        asg_r[18:16] <= ISCS_SRC_ALM3;
      end else if (wr_fire && wa == `ISCS_A_ASSIGN) begin
        asg_r <= {13'd0, wd[18:16], 1'b0, wd[14:12], 1'b0, wd[10:8], 1'b0,
                  wd[6:4], 1'b0, wd[2:0]};
      end
    end
  end

  // Linear scaling with round-half-away-from-zero
  // Wide intermediate keeps the full span product exact
  logic signed [33:0] num;
  logic signed [33:0] den2;
  logic signed [33:0] qrnd;
  assign num  = 34'(scl_hi_r - scl_lo_r) * $signed({18'd0, adc_s2_r});
  assign den2 = $signed({17'd0, ADC_FULL, 1'b0});
  assign qrnd = (num * 34'sd2 + (num < 0 ? -$signed({18'd0, ADC_FULL})
                                         : $signed({18'd0, ADC_FULL}))) / den2;
  always_ff @(posedge clk_i) begin
    if (!resetn_i)
      pv_r <= 16'h0000;
    else if (analog)
      pv_r <= scl_lo_r + 16'(qrnd);
    else
      pv_r <= tpv_s2_r;
  end
  assign pv_o = pv_r;
  // Decimal count only meaningful for analog input
  assign pv_decimals_o = analog ? dec_r : 2'b01;

  // Proportional split around the set point
  // Error uses the registered PV, three cycles behind the pins
  logic signed [17:0] err, half;
  logic [31:0] cool_band;
  logic [7:0]  h_raw, c_raw;
  assign err  = 18'(sp_r) - 18'(pv_r);
  // Dead band centred on SP; negative width overlaps
  assign half = hc ? 18'(dband_r) >>> 1 : 18'sd0;
  // Cooling band in hundredths of the base band
  assign cool_band = 32'(pband_r) * 32'(coef_r[pid_sel]) / 32'd100;
  always_comb begin
    if (hc) begin
      h_raw = prop_mv(err - half, 32'(pband_r));
      c_raw = prop_mv(-err - half, cool_band);
    end else begin
      h_raw = prop_mv(direct_eff ? -err : err, 32'(pband_r));
      c_raw = 8'h00;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mvh_r <= 8'h00;
      mvc_r <= 8'h00;
    end else if (hc && direct_eff) begin
      mvh_r <= c_raw;
      mvc_r <= h_raw;
    end else begin
      mvh_r <= h_raw;
      mvc_r <= c_raw;
    end
  end
  assign mv_heat_o = mvh_r;
  assign mv_cool_o = mvc_r;

  // Route sources to physical outputs
  // Unknown codes read as off so a bad assignment drives nothing
  function automatic logic route(input logic [2:0] sel, input logic h,
                                 input logic c, input logic [2:0] a);
    case (sel)
      ISCS_SRC_HEAT: route = h;
      ISCS_SRC_COOL: route = c;
      ISCS_SRC_ALM1: route = a[0];
      ISCS_SRC_ALM2: route = a[1];
      ISCS_SRC_ALM3: route = a[2];
      default:       route = 1'b0;
    endcase
  endfunction : route

  logic hon, con;
  assign hon = mvh_r != 8'h00;
  assign con = mvc_r != 8'h00;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl_out1_o <= 1'b0;
      ctrl_out2_o <= 1'b0;
      aux_out_o   <= 3'b000;
    end else begin
      ctrl_out1_o  <= route(asg_r[2:0], hon, con, alm_s2_r);
      ctrl_out2_o  <= ctrl_r[`ISCS_B_HAS_O2] && route(asg_r[6:4], hon, con, alm_s2_r);
      // Program end overrides aux1 while program pattern is on
      aux_out_o[0] <= ctrl_r[`ISCS_B_PROG] ? pe_s2_r : route(asg_r[10:8], hon, con, alm_s2_r);
      aux_out_o[1] <= route(asg_r[14:12], hon, con, alm_s2_r);
      aux_out_o[2] <= route(asg_r[18:16], hon, con, alm_s2_r);
    end
  end

  // Read channel; hidden settings read as zero
  // Read data is captured at the address edge, not live
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    case (s_axi_araddr_i)
      `ISCS_A_CTRL:   rmux = ctrl_r;
      `ISCS_A_SCL_HI: rmux = analog ? 32'(scl_hi_r) : 32'h0000_0000;
      `ISCS_A_SCL_LO: rmux = analog ? 32'(scl_lo_r) : 32'h0000_0000;
      `ISCS_A_DEC:    rmux = analog ? 32'(dec_r) : 32'h0000_0000;
      `ISCS_A_DBAND:  rmux = hc ? 32'(dband_r) : 32'h0000_0000;
      `ISCS_A_COEF:   rmux = hc ? 32'(coef_r[pid_sel]) : 32'h0000_0000;
      `ISCS_A_PBAND:  rmux = 32'(pband_r);
      `ISCS_A_SP:     rmux = 32'(sp_r);
      `ISCS_A_ASSIGN: rmux = asg_r;
      `ISCS_A_PV:     rmux = {14'd0, pv_decimals_o, pv_r};
      `ISCS_A_MV:     rmux = {16'd0, mvc_r, mvh_r};
      `ISCS_A_STAT:   rmux = {26'd0, direct_eff, aux_out_o, ctrl_out2_o, ctrl_out1_o};
      default:        rmux = 32'h0000_0000;
    endcase
  end
  // One read outstanding: no new address while data waits
  assign s_axi_arready_o = !rvalid_r;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= 2'b00;
    end else if (s_axi_arvalid_i && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rmux;
      rresp_r  <= (s_axi_araddr_i[1:0] == 2'b00 && s_axi_araddr_i <= `ISCS_A_STAT)
                  ? 2'b00 : 2'b10;
    end else if (rvalid_r && s_axi_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o  = rdata_r;
  assign s_axi_rresp_o  = rresp_r;
endmodule : iscs_top

// file: sim/iscs_chk.sv
// Bus handshake and output range checker for the scaling and split block
`timescale 1ns/1ps
module iscs_chk #(
  parameter logic [15:0] ADC_FULL = 16'hFFFF
) (
  input wire logic        clk_i, resetn_i,
  input wire logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o,
  input wire logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o,
  input wire logic        s_axi_rvalid_o, s_axi_rready_i,
  input wire logic [1:0]  s_axi_bresp_o, s_axi_rresp_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [7:0]  mv_heat_o, mv_cool_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  AST_B_RISE: assert property (wr_take |=> s_axi_bvalid_o)
    else $error("write response missing");
  AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  AST_B_DROP: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response repeated");
  AST_B_BLOCK: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while response pending");
  AST_R_RISE: assert property (rd_take |=> s_axi_rvalid_o)
    else $error("read data missing");
  AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read data changed");
  AST_AR_BLOCK: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read accepted while data pending");
  // Percent outputs must never pass full scale, even with overlap
  AST_MV_LIMIT: assert property (mv_heat_o <= 8'h64 && mv_cool_o <= 8'h64)
    else $error("output above full scale");
endmodule : iscs_chk

bind iscs_top iscs_chk #(.ADC_FULL(ADC_FULL)) u_chk (.clk_i, .resetn_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_bresp_o, .s_axi_rresp_o, .s_axi_rdata_o, .mv_heat_o, .mv_cool_o);

// file: sim/iscs_plant.sv
// Process sensor stand-in feeding the analog and temperature pins
`timescale 1ns/1ps
module iscs_plant (
  input wire logic        clk_i,
  input wire logic [7:0]  mv_heat_i, mv_cool_i,
  output logic     [15:0] adc_raw_o, temp_pv_o
);
  logic [15:0] raw_r = 16'h0000;
  task automatic set_raw(input logic [15:0] v);
    @(posedge clk_i);
    raw_r <= v;
  endtask : set_raw
  // Held steady: noise would hide rounding slips
  assign adc_raw_o = raw_r;
  assign temp_pv_o = 16'h00FA;
endmodule : iscs_plant

// file: sim/test_iscs_top.sv
// Directed bus-level test of the scaling and heat/cool split block
`timescale 1ns/1ps
`include "iscs_defs.svh"
module test_iscs_top;
  logic clk_i, resetn_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  logic event_in_i, prog_end_i, auto_tuning_done_i, ctrl_out1_o, ctrl_out2_o;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i, mv_heat_o, mv_cool_o;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd_d;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, pv_decimals_o, rd_r, wr_b;
  logic [15:0] adc_raw_i, temp_pv_i, auto_tuning_coef_i, pv_o;
  logic [2:0] alarm_i, aux_out_o;
  int error_cnt, checked;

  iscs_top dut_u (.clk_i, .resetn_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .adc_raw_i, .temp_pv_i, .event_in_i, .alarm_i, .prog_end_i, .auto_tuning_done_i,
    .auto_tuning_coef_i, .ctrl_out1_o, .ctrl_out2_o, .aux_out_o, .mv_heat_o, .mv_cool_o, .pv_o, .pv_decimals_o);
  iscs_plant plant_u (.clk_i, .mv_heat_i(mv_heat_o), .mv_cool_i(mv_cool_o), .adc_raw_o(adc_raw_i),
    .temp_pv_o(temp_pv_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic tally_and_finish;
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : chk

  // Ready is judged at the falling edge so the handshake edge is never raced
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge clk_i);
      ah = s_axi_awvalid_i && s_axi_awready_o;
      wh = s_axi_wvalid_i && s_axi_wready_o;
      bh = s_axi_bvalid_o === 1'b1;
      wr_b = s_axi_bresp_o;
      @(posedge clk_i);
      if (ah) s_axi_awvalid_i <= 1'b0;
      if (wh) s_axi_wvalid_i <= 1'b0;
      if (bh) s_axi_bready_i <= 1'b0;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ah, rh;
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge clk_i);
      ah = s_axi_arvalid_i && s_axi_arready_o;
      rh = s_axi_rvalid_o === 1'b1;
      rd_d = s_axi_rdata_o;
      rd_r = s_axi_rresp_o;
      @(posedge clk_i);
      if (ah) s_axi_arvalid_i <= 1'b0;
      if (rh) s_axi_rready_i <= 1'b0;
    end
  endtask : rd

  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, e, rd_d);
  endtask : rc

  // Pin path is sync, pv, mv and output stages: eight edges cover it
  task automatic st;
    repeat (8) @(posedge clk_i);
  endtask : st

  task automatic sc(input logic [15:0] r, input logic [15:0] e);
    plant_u.set_raw(r);
    st();
    chk("pv", 32'(e), 32'(pv_o));
  endtask : sc

  task automatic mvc(input logic [7:0] h, input logic [7:0] c);
    st();
    chk("mv_heat", 32'(h), 32'(mv_heat_o));
    chk("mv_cool", 32'(c), 32'(mv_cool_o));
  endtask : mvc

  task automatic pulse;
    @(posedge clk_i);
    auto_tuning_done_i <= 1'b1;
    @(posedge clk_i);
    auto_tuning_done_i <= 1'b0;
  endtask : pulse

  initial begin
    #1_000_000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    {resetn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 6'h00;
    {event_in_i, prog_end_i, auto_tuning_done_i, alarm_i} = 6'h00;
    s_axi_awaddr_i = 8'h00;
    s_axi_araddr_i = 8'h00;
    s_axi_wdata_i = 32'h0000_0000;
    s_axi_wstrb_i = 4'hF;
    auto_tuning_coef_i = 16'h00FA;
    error_cnt = 0;
    checked = 0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    rc("ctrl", `ISCS_A_CTRL, 32'h0000_0008);
    rc("assign", `ISCS_A_ASSIGN, 32'h0005_4301);
    rc("dband", `ISCS_A_DBAND, 32'h0000_0000);
    rc("coef_hide", `ISCS_A_COEF, 32'h0000_0000);
    st();
    chk("pv_temp", 32'h0000_00FA, 32'(pv_o));
    wr(`ISCS_A_SCL_HI, 32'h0000_01F4);
    rc("hi_lock", `ISCS_A_SCL_HI, 32'h0000_0000);
    wr(`ISCS_A_DBAND, 32'h0000_0004);
    rc("db_lock", `ISCS_A_DBAND, 32'h0000_0000);
    rd(8'h40);
    chk("unmapped", 32'h0000_0002, 32'(rd_r));
    wr(8'h40, 32'h0000_0001);
    chk("wr_unmapped", 32'h0000_0002, 32'(wr_b));
    wr(`ISCS_A_CTRL, 32'h0000_0009);
    chk("wr_okay", 32'h0000_0000, 32'(wr_b));
    rc("hi_keep", `ISCS_A_SCL_HI, 32'h0000_03E8);
    wr(`ISCS_A_SCL_HI, 32'h0000_03B6);
    wr(`ISCS_A_SCL_LO, 32'h0000_0064);
    wr(`ISCS_A_DEC, 32'h0000_0001);
    sc(16'h0000, 16'h0064);
    sc(16'hFFFF, 16'h03B6);
    sc(16'h0027, 16'h0065);
    wr(`ISCS_A_DEC, 32'h0000_0002);
    chk("decimals", 32'h0000_0002, 32'(pv_decimals_o));
    wr(`ISCS_A_CTRL, 32'h0000_000B);
    rc("asg_hc", `ISCS_A_ASSIGN, 32'h0005_4321);
    rc("db_rst", `ISCS_A_DBAND, 32'h0000_0000);
    rc("coef_rst", `ISCS_A_COEF, 32'h0000_0064);
    sc(16'h0000, 16'h0064);
    wr(`ISCS_A_SP, 32'h0000_008C);
    mvc(8'h32, 8'h00);
    wr(`ISCS_A_DBAND, 32'h0000_0014);
    rc("db_hc", `ISCS_A_DBAND, 32'h0000_0014);
    mvc(8'h25, 8'h00);
    wr(`ISCS_A_DBAND, 32'h0000_FFD8);
    wr(`ISCS_A_SP, 32'h0000_006E);
    mvc(8'h25, 8'h0C);
    wr(`ISCS_A_DBAND, 32'h0000_0000);
    wr(`ISCS_A_COEF, 32'h0000_00C8);
    wr(`ISCS_A_SP, 32'h0000_003C);
    mvc(8'h00, 8'h19);
    chk("out2_cool", 32'h0000_0001, 32'(ctrl_out2_o));
    wr(`ISCS_A_COEF, 32'h0000_0064);
    wr(`ISCS_A_SP, 32'h0000_008C);
    @(posedge clk_i);
    event_in_i <= 1'b1;
    wr(`ISCS_A_CTRL, 32'h0000_000F);
    mvc(8'h00, 8'h32);
    wr(`ISCS_A_CTRL, 32'h0000_002F);
    mvc(8'h32, 8'h00);
    @(posedge clk_i);
    event_in_i <= 1'b0;
    mvc(8'h00, 8'h32);
    wr(`ISCS_A_CTRL, 32'h0000_010B);
    wr(`ISCS_A_COEF, 32'h0000_012C);
    rc("coef1", `ISCS_A_COEF, 32'h0000_012C);
    wr(`ISCS_A_CTRL, 32'h0000_000B);
    rc("coef0", `ISCS_A_COEF, 32'h0000_0064);
    pulse();
    rc("at_off", `ISCS_A_COEF, 32'h0000_0064);
    wr(`ISCS_A_CTRL, 32'h0000_004B);
    pulse();
    rc("at_on", `ISCS_A_COEF, 32'h0000_00FA);
    wr(`ISCS_A_CTRL, 32'h0000_001B);
    @(posedge clk_i);
    prog_end_i <= 1'b1;
    st();
    chk("aux_prog", 32'h0000_0001, 32'(aux_out_o));
    @(posedge clk_i);
    prog_end_i <= 1'b0;
    alarm_i <= 3'b010;
    st();
    chk("aux_alarm", 32'h0000_0002, 32'(aux_out_o));
    chk("out1_heat", 32'h0000_0001, 32'(ctrl_out1_o));
    wr(`ISCS_A_CTRL, 32'h0000_0009);
    rc("asg_std", `ISCS_A_ASSIGN, 32'h0005_4301);
    wr(`ISCS_A_SP, 32'h0000_003C);
    mvc(8'h00, 8'h00);
    wr(`ISCS_A_CTRL, 32'h0000_0003);
    rc("asg_no2", `ISCS_A_ASSIGN, 32'h0005_2301);
    tally_and_finish();
  end
endmodule : test_iscs_top
